// ### logic/param_page_reader.sv
`timescale 1ns/1ps
`include "param_page_consts.svh"

module param_page_reader (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // link
    param_page_if.reader     link,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // command sequencer side
    output logic             caps_valid,
    output logic [3:0]       alt_cmd_allowed,
    output logic [3:0]       row_addr_cycles,
    output logic [3:0]       col_addr_cycles
);

    param_page_pkg::reader_s st;
    param_page_pkg::reader_s next_st;
    logic                    addr_phase;

    assign addr_phase = hsel && htrans[1] && hready;

    // ==========================================================
    // register read mux
    function automatic logic [31:0] read_reg(input logic [31:0] a,
                                             input param_page_pkg::reader_s s);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == `RD_REG_USER_ADDR) begin
            d = {24'h0, s.user_addr};
        end else if (a == `RD_REG_STATUS) begin
            d[`RD_STAT_BUSY]       = s.state != param_page_pkg::RDR_IDLE;
            d[`RD_STAT_CAPS_VALID] = s.caps_valid;
            d[`RD_STAT_USER_DONE]  = s.user_done;
        end else if (a == `RD_REG_USER_DATA) begin
            d = {24'h0, s.user_data};
        end else if (a == `RD_REG_CAPS) begin
            d = {16'h0, s.col_cycles, s.row_cycles, 4'h0, s.alt_allowed};
        end
        return d;
    endfunction

    always_comb begin
        next_st = st;
        // ======================================================
        // bus: capture writes for the data phase, register read data now
        next_st.wr_pend = addr_phase && hwrite;
        if (addr_phase) begin
            next_st.wr_addr = haddr;
            next_st.hrdata  = hwrite ? 32'h0000_0000 : read_reg(haddr, st);
        end
        // ======================================================
        // table fetches; capabilities are refreshed before user reads
        case (st.state)
            param_page_pkg::RDR_IDLE: begin
                if (st.refetch) begin
                    next_st.refetch     = 1'b0;
                    // forbid every alternative form until the byte is back
                    next_st.caps_valid  = 1'b0;
                    next_st.alt_allowed = 4'h0;
                    next_st.rd_req      = 1'b1;
                    next_st.rd_addr     = `PP_ADV_CMD;
                    next_st.state       = param_page_pkg::RDR_FETCH_ADV;
                end else if (st.user_pend) begin
                    next_st.user_pend = 1'b0;
                    next_st.rd_req    = 1'b1;
                    next_st.rd_addr   = st.user_addr;
                    next_st.state     = param_page_pkg::RDR_FETCH_USR;
                end
            end
            param_page_pkg::RDR_FETCH_ADV: begin
                if (link.rd_ack) begin
                    next_st.alt_allowed = link.rd_data[3:0];
                    next_st.rd_addr     = `PP_ADDR_CYCLES;
                    next_st.state       = param_page_pkg::RDR_FETCH_CYC;
                end
            end
            param_page_pkg::RDR_FETCH_CYC: begin
                if (link.rd_ack) begin
                    next_st.rd_req     = 1'b0;
                    next_st.row_cycles = link.rd_data[3:0];
                    next_st.col_cycles = link.rd_data[7:4];
                    next_st.caps_valid = 1'b1;
                    next_st.state      = param_page_pkg::RDR_IDLE;
                end
            end
            param_page_pkg::RDR_FETCH_USR: begin
                if (link.rd_ack) begin
                    next_st.rd_req    = 1'b0;
                    next_st.user_data = link.rd_data;
                    next_st.user_done = 1'b1;
                    next_st.state     = param_page_pkg::RDR_IDLE;
                end
            end
            default: begin
                next_st.state = param_page_pkg::RDR_IDLE;
            end
        endcase
        // register writes come after the fetch case: a request landing with a clear is never lost
        if (st.wr_pend) begin
            if (st.wr_addr == `RD_REG_CTRL && hwdata[`RD_CTRL_REFETCH]) begin
                next_st.refetch = 1'b1;
            end else if (st.wr_addr == `RD_REG_USER_ADDR) begin
                next_st.user_addr = hwdata[7:0];
                next_st.user_pend = 1'b1;
                next_st.user_done = 1'b0;
            end
        end
        // a request kept high across an ack would hold the target in TGT_ANSWER
        if (link.rd_ack && st.state == param_page_pkg::RDR_FETCH_ADV) begin
            next_st.rd_req = 1'b0;
        end
        if (st.state == param_page_pkg::RDR_FETCH_CYC && !st.rd_req && !link.rd_ack) begin
            next_st.rd_req = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st         <= '0;
            st.refetch <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign link.rd_req     = st.rd_req;
    assign link.rd_addr    = st.rd_addr;
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign hrdata          = st.hrdata;
    assign caps_valid      = st.caps_valid;
    assign alt_cmd_allowed = st.alt_allowed;
    assign row_addr_cycles = st.row_cycles;
    assign col_addr_cycles = st.col_cycles;

endmodule // param_page_reader

// ### logic/param_page_target.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "param_page_consts.svh"

// Functional notes
// - bit0: alternative random data output supported
// - bit1: alternative multi-plane program supported
// - bit2: alternative multi-plane copyback supported
// - bit3: alternative multi-plane erase supported
// - advanced command bits 4-7 read zero
// - extended length in 16-byte units, minimum 3
// - copy count includes original table
// - maker name twelve bytes, space padded
// - model name twenty bytes, space padded
// - one-byte vendor code at position 64
// - date is year, week; zero if absent
// - page data bytes power of two, >=512
// - pages per block multiple of 32
// - unit count nonzero, numbered from zero
// - row and column cycle nibbles nonzero
// - host sends reported address cycle counts
// - bits per cell nonzero, FFh unspecified
// - endurance value byte times ten^exponent
// - write-once 1,0; read-only 0,0
// - endurance value byte kept smallest
// - guaranteed good blocks at least one
// - good block endurance plain binary count
// - extended fields only with feature bit
module param_page_target #(
    parameter logic [95:0]  MAKER_NAME       = "MAKER",
    parameter logic [159:0] MODEL_NAME       = "MODEL",
    // arbitrary neutral value
    parameter logic [7:0]   VENDOR_CODE      = 8'h5A,
    parameter bit           DATE_ENABLED     = 1'b0,
    parameter logic [7:0]   DATE_YEAR        = 8'h00,
    parameter logic [7:0]   DATE_WEEK        = 8'h00,
    parameter logic [3:0]   ADV_CMD          = 4'h0,
    parameter bit           EXT_SUPPORTED    = 1'b0,
    parameter logic [15:0]  EXT_LENGTH       = 16'h0003,
    parameter logic [7:0]   COPY_COUNT       = 8'h03,
    parameter logic [31:0]  DATA_BYTES       = 32'h0000_0800,
    parameter logic [15:0]  SPARE_BYTES      = 16'h0040,
    parameter logic [31:0]  PAGES_PER_BLOCK  = 32'h0000_0040,
    parameter logic [31:0]  BLOCKS_PER_UNIT  = 32'h0000_0400,
    parameter logic [7:0]   UNIT_COUNT       = 8'h01,
    parameter logic [3:0]   ROW_CYCLES       = 4'h3,
    parameter logic [3:0]   COL_CYCLES       = 4'h2,
    parameter logic [7:0]   BITS_PER_CELL    = 8'h01,
    parameter logic [15:0]  MAX_BAD_BLOCKS   = 16'h0014,
    parameter logic [31:0]  ENDURANCE_CYCLES = 32'h0001_86A0,
    parameter logic [7:0]   GOOD_BLOCKS      = 8'h01,
    parameter logic [15:0]  GOOD_ENDURANCE   = 16'h0000
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // link
    param_page_if.target    link,
    // status
    output logic            config_ok
);

    // ==========================================================
    // table contents
    function automatic logic [7:0] le_byte(input logic [31:0] v, input logic [7:0] idx);
        logic [31:0] s;
        s = v >> {idx[1:0], 3'b000};
        return s[7:0];
    endfunction

    // left-justify a string and fill the unused tail with spaces
    function automatic logic [159:0] pad_string(input logic [159:0] s, input int len);
        logic [159:0] r;
        r = s;
        for (int i = 0; i < 20; i++) begin
            if (r != '0 && r[len*8-1 -: 8] == 8'h00) begin
                r = r << 8;
            end
        end
        for (int k = 0; k < 20; k++) begin
            if (k < len && r[k*8 +: 8] == 8'h00) begin
                r[k*8 +: 8] = `PP_STRING_PAD;
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] string_byte(input logic [159:0] s, input int len,
                                               input logic [7:0] idx);
        logic [159:0] t;
        t = s >> ((len - 1 - int'(idx)) * 8);
        return t[7:0];
    endfunction

    // strip factors of ten into the exponent so the value byte is smallest
    function automatic logic [15:0] encode_endurance(input logic [31:0] cycles);
        logic [31:0] v;
        logic [7:0]  e;
        v = cycles;
        e = 8'h00;
        for (int i = 0; i < 10; i++) begin
            if (v != 32'h0 && v % 32'd10 == 32'h0) begin
                v = v / 32'd10;
                e = e + 8'h01;
            end
        end
        return {e, v[7:0]};
    endfunction

    localparam logic [159:0] MAKER_PADDED = pad_string({64'h0, MAKER_NAME}, `PP_MAKER_LEN);
    localparam logic [159:0] MODEL_PADDED = pad_string(MODEL_NAME, `PP_MODEL_LEN);
    localparam logic [15:0]  ENDURANCE    = encode_endurance(ENDURANCE_CYCLES);
    localparam logic [15:0]  EXT_LEN_RPT  =
        (EXT_LENGTH < `PP_MIN_EXT_LEN) ? `PP_MIN_EXT_LEN : EXT_LENGTH;

    function automatic logic [7:0] table_byte(input logic [7:0] a);
        logic [7:0] b;
        b = 8'h00;
        if (a == `PP_FEATURES_HI) begin
            b = {EXT_SUPPORTED, 7'h00};
        end else if (a == `PP_ADV_CMD) begin
            b = {4'h0, ADV_CMD};
        end else if (a == `PP_EXT_LEN_LO || a == `PP_EXT_LEN_HI) begin
            b = EXT_SUPPORTED ? le_byte({16'h0, EXT_LEN_RPT}, a - `PP_EXT_LEN_LO) : 8'h00;
        end else if (a == `PP_COPY_COUNT) begin
            b = EXT_SUPPORTED ? COPY_COUNT : 8'h00;
        end else if (a >= `PP_MAKER_FIRST && a <= `PP_MAKER_LAST) begin
            b = string_byte(MAKER_PADDED, `PP_MAKER_LEN, a - `PP_MAKER_FIRST);
        end else if (a >= `PP_MODEL_FIRST && a <= `PP_MODEL_LAST) begin
            b = string_byte(MODEL_PADDED, `PP_MODEL_LEN, a - `PP_MODEL_FIRST);
        end else if (a == `PP_VENDOR_CODE) begin
            b = VENDOR_CODE;
        end else if (a == `PP_DATE_YEAR) begin
            b = DATE_ENABLED ? DATE_YEAR : 8'h00;
        end else if (a == `PP_DATE_WEEK) begin
            b = DATE_ENABLED ? DATE_WEEK : 8'h00;
        end else if (a >= `PP_DATA_BYTES && a < `PP_SPARE_BYTES) begin
            b = le_byte(DATA_BYTES, a - `PP_DATA_BYTES);
        end else if (a >= `PP_SPARE_BYTES && a < `PP_SPARE_BYTES + 8'h02) begin
            b = le_byte({16'h0, SPARE_BYTES}, a - `PP_SPARE_BYTES);
        end else if (a >= `PP_PAGES_PER_BLOCK && a < `PP_BLOCKS_PER_UNIT) begin
            b = le_byte(PAGES_PER_BLOCK, a - `PP_PAGES_PER_BLOCK);
        end else if (a >= `PP_BLOCKS_PER_UNIT && a < `PP_UNIT_COUNT) begin
            b = le_byte(BLOCKS_PER_UNIT, a - `PP_BLOCKS_PER_UNIT);
        end else if (a == `PP_UNIT_COUNT) begin
            b = UNIT_COUNT;
        end else if (a == `PP_ADDR_CYCLES) begin
            b = {COL_CYCLES, ROW_CYCLES};
        end else if (a == `PP_BITS_PER_CELL) begin
            b = BITS_PER_CELL;
        end else if (a >= `PP_MAX_BAD_BLOCKS && a < `PP_ENDUR_VALUE) begin
            b = le_byte({16'h0, MAX_BAD_BLOCKS}, a - `PP_MAX_BAD_BLOCKS);
        end else if (a == `PP_ENDUR_VALUE) begin
            b = ENDURANCE[7:0];
        end else if (a == `PP_ENDUR_EXP) begin
            b = ENDURANCE[15:8];
        end else if (a == `PP_GOOD_BLOCKS) begin
            b = GOOD_BLOCKS;
        end else if (a >= `PP_GOOD_ENDURANCE && a < `PP_GOOD_ENDURANCE + 8'h02) begin
            b = le_byte({16'h0, GOOD_ENDURANCE}, a - `PP_GOOD_ENDURANCE);
        end
        return b;
    endfunction

    // ==========================================================
    // parameter sanity, flagged rather than silently corrected
    localparam bit DATA_OK  = DATA_BYTES >= `PP_MIN_DATA_BYTES &&
                              (DATA_BYTES & (DATA_BYTES - 32'h1)) == 32'h0;
    localparam bit PAGES_OK = PAGES_PER_BLOCK != 32'h0 &&
                              PAGES_PER_BLOCK % `PP_PAGES_MULTIPLE == 0;
    localparam bit GEOM_OK  = UNIT_COUNT != 8'h00 && ROW_CYCLES != 4'h0 &&
                              COL_CYCLES != 4'h0;
    localparam bit CELL_OK  = BITS_PER_CELL != 8'h00 && GOOD_BLOCKS != 8'h00;
    localparam bit EXT_OK   = !EXT_SUPPORTED ||
                              (EXT_LENGTH >= `PP_MIN_EXT_LEN && COPY_COUNT != 8'h00);
    localparam bit END_OK   = ENDURANCE_CYCLES ==
                              32'(ENDURANCE[7:0]) * (32'd10 ** ENDURANCE[15:8]);
    localparam bit ALL_OK   = DATA_OK && PAGES_OK && GEOM_OK && CELL_OK && EXT_OK && END_OK;

    // ==========================================================
    // link answer: one ack per request, data registered with it
    param_page_pkg::target_s st;
    param_page_pkg::target_s next_st;

    always_comb begin
        next_st           = st;
        next_st.rd_ack    = 1'b0;
        next_st.config_ok = ALL_OK;
        case (st.state)
            param_page_pkg::TGT_IDLE: begin
                if (link.rd_req) begin
                    next_st.rd_ack  = 1'b1;
                    next_st.rd_data = table_byte(link.rd_addr);
                    next_st.state   = param_page_pkg::TGT_ANSWER;
                end
            end
            param_page_pkg::TGT_ANSWER: begin
                // wait for the request to drop so one request is not served twice
                if (!link.rd_req && !st.rd_ack) begin
                    next_st.state = param_page_pkg::TGT_IDLE;
                end
            end
            default: begin
                next_st.state = param_page_pkg::TGT_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.rd_ack  = st.rd_ack;
    assign link.rd_data = st.rd_data;
    assign config_ok    = st.config_ok;

endmodule // param_page_target

// ### shared/param_page_consts.svh
`ifndef PARAM_PAGE_CONSTS_SVH
`define PARAM_PAGE_CONSTS_SVH

// ==========================================================
// table byte positions
`define PP_FEATURES_HI       8'h07
`define PP_ADV_CMD           8'h0A
`define PP_EXT_LEN_LO        8'h0C
`define PP_EXT_LEN_HI        8'h0D
`define PP_COPY_COUNT        8'h0E
`define PP_MAKER_FIRST       8'h20
`define PP_MAKER_LAST        8'h2B
`define PP_MODEL_FIRST       8'h2C
`define PP_MODEL_LAST        8'h3F
`define PP_VENDOR_CODE       8'h40
`define PP_DATE_YEAR         8'h41
`define PP_DATE_WEEK         8'h42
`define PP_DATA_BYTES        8'h50
`define PP_SPARE_BYTES       8'h54
`define PP_PAGES_PER_BLOCK   8'h5C
`define PP_BLOCKS_PER_UNIT   8'h60
`define PP_UNIT_COUNT        8'h64
`define PP_ADDR_CYCLES       8'h65
`define PP_BITS_PER_CELL     8'h66
`define PP_MAX_BAD_BLOCKS    8'h67
`define PP_ENDUR_VALUE       8'h69
`define PP_ENDUR_EXP         8'h6A
`define PP_GOOD_BLOCKS       8'h6B
`define PP_GOOD_ENDURANCE    8'h6C

// ==========================================================
// field limits and fill values
`define PP_STRING_PAD        8'h20
`define PP_MAKER_LEN         12
`define PP_MODEL_LEN         20
`define PP_MIN_DATA_BYTES    512
`define PP_PAGES_MULTIPLE    32
`define PP_MIN_EXT_LEN       16'h0003
`define PP_ADV_CMD_BITS      4

// ==========================================================
// reader register map (byte addresses) and fields
`define RD_REG_CTRL          32'h0000_0000
`define RD_REG_USER_ADDR     32'h0000_0004
`define RD_REG_STATUS        32'h0000_0008
`define RD_REG_USER_DATA     32'h0000_000C
`define RD_REG_CAPS          32'h0000_0010
`define RD_CTRL_REFETCH      0
`define RD_STAT_BUSY         0
`define RD_STAT_CAPS_VALID   1
`define RD_STAT_USER_DONE    2

`endif

// ### shared/param_page_if.sv
`timescale 1ns/1ps

// ==========================================================
// byte read link between table reader and target
interface param_page_if;
    logic       rd_req;
    logic [7:0] rd_addr;
    logic       rd_ack;
    logic [7:0] rd_data;

    modport target (
        input  rd_req,
        input  rd_addr,
        output rd_ack,
        output rd_data
    );

    modport reader (
        output rd_req,
        output rd_addr,
        input  rd_ack,
        input  rd_data
    );
endinterface

// ### shared/param_page_pkg.sv
package param_page_pkg;

    // ==========================================================
    // target end
    typedef enum logic [0:0] {
        TGT_IDLE   = 1'b0,
        TGT_ANSWER = 1'b1
    } target_state_e;

    typedef struct packed {
        target_state_e state;
        logic          rd_ack;
        logic [7:0]    rd_data;
        logic          config_ok;
    } target_s;

    // ==========================================================
    // reader end
    typedef enum logic [1:0] {
        RDR_IDLE      = 2'b00,
        RDR_FETCH_ADV = 2'b01,
        RDR_FETCH_CYC = 2'b10,
        RDR_FETCH_USR = 2'b11
    } reader_state_e;

    typedef struct packed {
        reader_state_e state;
        logic          rd_req;
        logic [7:0]    rd_addr;
        logic          refetch;
        logic          caps_valid;
        logic [3:0]    alt_allowed;
        logic [3:0]    row_cycles;
        logic [3:0]    col_cycles;
        logic          user_pend;
        logic [7:0]    user_addr;
        logic [7:0]    user_data;
        logic          user_done;
        logic          wr_pend;
        logic [31:0]   wr_addr;
        logic [31:0]   hrdata;
    } reader_s;

endpackage

// ### tb/param_page_chk.sv
`timescale 1ns/1ps

// ==========================================================
// link checker: watches both ends across the byte link
module param_page_chk (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_b,
    // link
    input wire logic       rd_req,
    input wire logic [7:0] rd_addr,
    input wire logic       rd_ack,
    input wire logic [7:0] rd_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_take;
        $rose(rd_req);
    endsequence
    sequence s_answer;
        rd_ack ##1 !rd_ack;
    endsequence

    property p_answer;
        s_take |=> s_answer;
    endproperty
    property p_req_drop;
        rd_ack |=> !rd_req;
    endproperty
    property p_addr_hold;
        rd_req && !rd_ack |=> $stable(rd_addr);
    endproperty
    property p_adv_rsvd;
        rd_ack && rd_addr == 8'h0A |-> rd_data[7:4] == 4'h0;
    endproperty
    property p_cycles;
        rd_ack && rd_addr == 8'h65 |-> rd_data[3:0] != 4'h0 && rd_data[7:4] != 4'h0;
    endproperty
    property p_nonzero;
        rd_ack && rd_addr inside {8'h64, 8'h66, 8'h6B} |-> rd_data != 8'h00;
    endproperty
    property p_ascii;
        rd_ack && rd_addr inside {[8'h20:8'h3F]} |-> rd_data inside {[8'h20:8'h7E]};
    endproperty
    property p_obsolete;
        rd_ack && rd_addr inside {[8'h56:8'h5B]} |-> rd_data == 8'h00;
    endproperty
    property p_endur_norm;
        rd_ack && rd_addr == 8'h69 |-> rd_data == 8'h00 || rd_data % 10 != 0;
    endproperty

    a_answer: assert property (p_answer) else $error("link answer not one cycle");
    a_req_drop: assert property (p_req_drop) else $error("request held after ack");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in request");
    a_adv_rsvd: assert property (p_adv_rsvd) else $error("reserved command bits set");
    a_cycles: assert property (p_cycles) else $error("address cycle nibble zero");
    a_nonzero: assert property (p_nonzero) else $error("count field zero");
    a_ascii: assert property (p_ascii) else $error("string byte not printable");
    a_obsolete: assert property (p_obsolete) else $error("obsolete byte not zero");
    a_endur_norm: assert property (p_endur_norm) else $error("endurance not normalized");
endmodule // param_page_chk

// ### tb/test_nand_parameter_page_fields.sv
`timescale 1ns/1ps

module test_nand_parameter_page_fields;
    logic        core_clk = 1'b0;
    logic        rst_b    = 1'b0;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0000_0000;
    logic [1:0]  htrans   = 2'b00;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0000_0000;
    logic        hreadyout, hresp, config_ok, caps_valid;
    logic [31:0] hrdata, rd;
    logic [3:0]  alt_cmd_allowed, row_addr_cycles, col_addr_cycles;
    int          fails = 0;
    int          n_compared = 0;
    // position in the high byte, expected table byte in the low byte
    logic [15:0] tbl [27] = '{16'h0A00, 16'h0C00, 16'h0D00, 16'h0E00, 16'h204D, 16'h2520,
        16'h2B20, 16'h2C4D, 16'h3F20, 16'h405A, 16'h4100, 16'h4200, 16'h5000, 16'h5108,
        16'h5440, 16'h5600, 16'h5A00, 16'h5C40, 16'h6401, 16'h6523, 16'h6601, 16'h6901,
        16'h6A05, 16'h6B01, 16'h6C00, 16'h6D00, 16'h7000};

    param_page_if param_page_if_i ();
    param_page_target param_page_target_i (.core_clk(core_clk), .rst_b(rst_b),
        .link(param_page_if_i), .config_ok(config_ok));
    param_page_reader param_page_reader_i (.core_clk(core_clk), .rst_b(rst_b),
        .link(param_page_if_i), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .caps_valid(caps_valid),
        .alt_cmd_allowed(alt_cmd_allowed), .row_addr_cycles(row_addr_cycles),
        .col_addr_cycles(col_addr_cycles));
    // second pair with alternative forms allowed, so the capability capture can fail
    logic        alt_caps_valid;
    logic [3:0]  alt_allowed, alt_row, alt_col;
    param_page_if param_page_if_alt_i ();
    param_page_target #(.ADV_CMD(4'hA), .ROW_CYCLES(4'h4), .COL_CYCLES(4'h1))
        param_page_target_alt_i (.core_clk(core_clk), .rst_b(rst_b),
        .link(param_page_if_alt_i), .config_ok());
    param_page_reader param_page_reader_alt_i (.core_clk(core_clk), .rst_b(rst_b),
        .link(param_page_if_alt_i), .hsel(1'b0), .haddr(32'h0000_0000), .htrans(2'b00),
        .hwrite(1'b0), .hsize(3'b010), .hwdata(32'h0000_0000), .hready(1'b1),
        .hreadyout(), .hresp(), .hrdata(), .caps_valid(alt_caps_valid),
        .alt_cmd_allowed(alt_allowed), .row_addr_cycles(alt_row),
        .col_addr_cycles(alt_col));
    param_page_chk param_page_chk_i (.core_clk(core_clk), .rst_b(rst_b),
        .rd_req(param_page_if_i.rd_req), .rd_addr(param_page_if_i.rd_addr),
        .rd_ack(param_page_if_i.rd_ack), .rd_data(param_page_if_i.rd_data));

    // ==========================================================
    // common tasks
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task end_sim();
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
             output logic [31:0] d);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    // one table byte through the user fetch registers; waits on the done flag
    task fetch(input logic [7:0] a, output logic [31:0] d);
        ahb(1'b1, 32'h0000_0004, {24'h000000, a}, d);
        d = 32'h0000_0000;
        for (int i = 0; i < 30 && d[2] !== 1'b1; i++) ahb(1'b0, 32'h0000_0008, 32'h0, d);
        ahb(1'b0, 32'h0000_000C, 32'h0, d);
    endtask

    // ==========================================================
    // scenarios
    task s_caps();
        for (int i = 0; i < 50 && caps_valid !== 1'b1; i++) @(posedge core_clk);
        chk("alt_cmd_allowed", {28'h0, alt_cmd_allowed}, 32'h0);
        chk("row_addr_cycles", {28'h0, row_addr_cycles}, 32'h3);
        chk("col_addr_cycles", {28'h0, col_addr_cycles}, 32'h2);
        chk("config_ok", {31'h0, config_ok}, 32'h1);
        chk("alt caps", {19'h0, alt_caps_valid, alt_col, alt_row, alt_allowed}, 32'h0000_114A);
        ahb(1'b0, 32'h0000_0010, 32'h0, rd);
        chk("caps", rd, 32'h0000_2300);
    endtask

    task s_table();
        foreach (tbl[i]) begin
            fetch(tbl[i][15:8], rd);
            chk("table byte", rd, {24'h0, tbl[i][7:0]});
        end
    endtask

    // read-only and unmapped places, then a capability refetch
    task s_refuse();
        ahb(1'b1, 32'h0000_000C, 32'hFFFF_FFFF, rd);
        ahb(1'b1, 32'h0000_0010, 32'h0000_0000, rd);
        ahb(1'b0, 32'h0000_000C, 32'h0, rd);
        chk("user_data ro", rd, 32'h0);
        ahb(1'b0, 32'h0000_0040, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001, rd);
        ahb(1'b0, 32'h0000_0008, 32'h0, rd);
        chk("status in refetch", rd, 32'h0000_0005);
        rd = 32'h0;
        for (int i = 0; i < 30 && rd[1:0] !== 2'b10; i++) ahb(1'b0, 32'h0000_0008, 32'h0, rd);
        ahb(1'b0, 32'h0000_0010, 32'h0, rd);
        chk("caps refetch", rd, 32'h0000_2300);
    endtask

    initial forever #12.5 core_clk = ~core_clk;

    initial begin
        #200us;
        fails++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        s_caps();
        s_table();
        s_refuse();
        end_sim();
    end
endmodule // test_nand_parameter_page_fields
